// ==== verif/cstm_host_model.sv ====
// Host firmware model that picks the operational state after self-test.
module cstm_host_model (
	input wire logic clk_sys,
	input wire logic want_apr,
	output logic host_approved_sel
);
	timeunit 1ns;
	timeprecision 1ps;
	initial host_approved_sel = 1'b0;
	always @(negedge clk_sys) host_approved_sel <= want_apr;
	// The host repeats the tests only through power-on reset.
endmodule : cstm_host_model

// ==== verif/cstm_monitor_assertions.sv ====
// Concurrent checks on the self-test monitor ports.
module cstm_monitor_assertions (
	input logic clk_sys,
	input logic reset_n,
	input logic trng_valid,
	input logic [15:0] trng_block,
	input logic keygen_done,
	input logic keygen_pair_ok,
	input logic fw_update_done,
	input logic fw_update_ok,
	input logic selftest_done,
	input logic secure_out_en,
	input logic public_out_en,
	input logic [1:0] status,
	input logic fw_update_accept,
	input logic keygen_accept,
	input logic in_error
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);
	logic [15:0] last_blk;
	logic have_blk;
	always_ff @(posedge clk_sys) begin
		if (!reset_n) have_blk <= 1'b0;
		else if (trng_valid) have_blk <= 1'b1;
	end
	always_ff @(posedge clk_sys) begin
		if (trng_valid) last_blk <= trng_block;
	end
	chk_out_gate: assert property (secure_out_en == selftest_done &&
		public_out_en == selftest_done) else $error("enable differs from done");
	chk_busy_status: assert property (!selftest_done && !in_error |-> status == 2'h0)
		else $error("status not busy before done");
	chk_done_status: assert property (selftest_done |-> status inside {2'h1, 2'h2})
		else $error("done without operational status");
	chk_error_status: assert property (in_error |-> status == 2'h3 && !selftest_done)
		else $error("error without error status");
	chk_error_latch: assert property (in_error |=> in_error)
		else $error("error left");
	chk_kg_accept: assert property (keygen_accept |->
		$past(keygen_done) && $past(keygen_pair_ok)) else $error("keygen accept uncaused");
	chk_kg_fail: assert property (selftest_done && keygen_done && !keygen_pair_ok
		|-> ##[1:2] in_error) else $error("keygen failure not error");
	chk_fw_accept: assert property (fw_update_accept |->
		$past(fw_update_done) && $past(fw_update_ok)) else $error("fw accept uncaused");
	chk_trng_repeat: assert property (trng_valid && have_blk && trng_block == last_blk
		|-> ##[1:3] in_error) else $error("repeated block not error");
	cov_approved: cover property (status == 2'h1);
	cov_non_approved: cover property (status == 2'h2);
	cov_error: cover property ($rose(in_error));
	cov_keygen: cover property (keygen_accept);
endmodule : cstm_monitor_assertions

bind cstm_monitor cstm_monitor_assertions u_chk (.clk_sys, .reset_n, .trng_valid, .trng_block,
	.keygen_done, .keygen_pair_ok, .fw_update_done, .fw_update_ok, .selftest_done,
	.secure_out_en, .public_out_en, .status, .fw_update_accept, .keygen_accept, .in_error);

// ==== verif/cstm_monitor_tb.sv ====
// Testbench for the self-test monitor.
module cstm_monitor_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, reset_n = 1'b0, want_apr = 1'b1, host_approved_sel;
	logic kat_done = 1'b0, srom_done = 1'b0, prom_valid = 1'b0, prom_last = 1'b0;
	logic fwsig_done = 1'b0, fwsig_ok = 1'b1, trng_valid = 1'b0, drbg_valid = 1'b0;
	logic keygen_done = 1'b0, keygen_is_ec = 1'b0, keygen_pair_ok = 1'b1;
	logic fw_update_done = 1'b0, fw_update_ok = 1'b1;
	logic [7:0] kat_match = 8'hfe, kat_is_pairwise = 8'h01, pairwise_ok = 8'h01;
	logic [3:0] drbg_step_pass = 4'hf;
	logic [255:0] srom_digest = 256'h5a, srom_expected = 256'h5a;
	logic [15:0] prom_word = 16'h0, trng_block = 16'h0;
	logic [127:0] drbg_block = 128'h0;
	logic selftest_done, secure_out_en, public_out_en, fw_update_accept, keygen_accept, in_error;
	logic [1:0] status;
	int mismatches = 0, total_checks = 0;
	always #2.5 clk_sys = ~clk_sys;
	cstm_host_model u_host (.clk_sys, .want_apr, .host_approved_sel);
	cstm_monitor u_dut (.clk_sys, .reset_n, .host_approved_sel, .kat_done, .kat_match,
		.kat_is_pairwise, .pairwise_ok, .drbg_step_pass, .srom_done, .srom_digest,
		.srom_expected, .prom_valid, .prom_word, .prom_last, .fwsig_done, .fwsig_ok,
		.trng_valid, .trng_block, .drbg_valid, .drbg_block, .keygen_done, .keygen_is_ec,
		.keygen_pair_ok, .fw_update_done, .fw_update_ok, .selftest_done, .secure_out_en,
		.public_out_en, .status, .fw_update_accept, .keygen_accept, .in_error);
	task chk(input string n, input logic [3:0] g, input logic [3:0] e);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task complete_run;
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	task cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	task boot(input int k);
		int i;
		kat_match = (k == 2) ? 8'hfc : 8'hfe;
		pairwise_ok = (k == 3) ? 8'h00 : 8'h01;
		drbg_step_pass = (k >= 4 && k <= 7) ? ~(4'h1 << (k - 4)) : 4'hf;
		srom_expected = (k == 8) ? 256'h5b : 256'h5a;
		fwsig_ok = (k != 10);
		want_apr = (k == 0);
		reset_n = 1'b0;
		cyc(4);
		reset_n = 1'b1;
		chk("busy", status, 2'h0);
		kat_done = 1'b1;
		cyc(1);
		kat_done = 1'b0;
		srom_done = 1'b1;
		cyc(1);
		srom_done = 1'b0;
		chk("gate", {secure_out_en, public_out_en}, 2'h0);
		prom_valid = 1'b1;
		prom_word = 16'h1234;
		cyc(1);
		prom_last = 1'b1;
		prom_word = (k == 9) ? 16'hedca : ~16'h1234;
		cyc(1);
		prom_valid = 1'b0;
		prom_last = 1'b0;
		fwsig_done = 1'b1;
		for (i = 0; i < 20 && status === 2'h0; i++) cyc(1);
		fwsig_done = 1'b0;
		if (i == 20) begin
			mismatches++;
			complete_run;
		end
		cyc(2);
		chk("status", status, k > 1 ? 2'h3 : (k == 0 ? 2'h1 : 2'h2));
		chk("gate", {secure_out_en, public_out_en}, {2{k < 2}});
		$display("boot %0d end", k);
	endtask : boot
	task rng(input logic d);
		int i;
		boot(0);
		for (i = 0; i < 4; i++) begin
			trng_valid = !d;
			drbg_valid = d;
			trng_block = 16'(i < 3 ? i : 2) << 12;
			drbg_block = 128'(i < 3 ? i : 2) << 120;
			cyc(1);
			trng_valid = 1'b0;
			drbg_valid = 1'b0;
			cyc(3);
			chk("rng_err", {1'b0, in_error}, {1'b0, i == 3});
		end
		chk("rng_gate", {status, public_out_en}, 3'h6);
		$display("rng %0d end", d);
	endtask : rng
	task ops;
		int e;
		boot(0);
		fw_update_ok = 1'b0;
		fw_update_done = 1'b1;
		cyc(1);
		chk("fw_bad", {status[0], fw_update_accept}, 2'h2);
		fw_update_ok = 1'b1;
		cyc(1);
		fw_update_done = 1'b0;
		chk("fw_ok", {1'b0, fw_update_accept}, 2'h1);
		for (e = 0; e < 2; e++) begin
			keygen_is_ec = e[0];
			keygen_done = 1'b1;
			cyc(1);
			keygen_done = 1'b0;
			chk("kg_ok", {1'b0, keygen_accept}, 2'h1);
			cyc(1);
		end
		keygen_pair_ok = 1'b0;
		keygen_done = 1'b1;
		cyc(1);
		keygen_done = 1'b0;
		keygen_pair_ok = 1'b1;
		fw_update_done = 1'b1;
		cyc(2);
		fw_update_done = 1'b0;
		chk("kg_err", {in_error, fw_update_accept}, 2'h2);
		$display("ops end");
	endtask : ops
	initial begin
		int k;
		for (k = 0; k < 11; k++) boot(k);
		rng(1'b0);
		rng(1'b1);
		ops;
		complete_run;
	end
endmodule : cstm_monitor_tb

// ==== verilog/cstm_crng.sv ====
// Continuous repeated-block check for one random generator.
module cstm_crng #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic blk_valid,
	input wire logic [W-1:0] blk_data,
	output logic fail
);
	initial begin
		if (W < 1) $error("cstm_crng: width must be positive.");
	end
	logic [W-1:0] prev;
	logic have_prev;
	wire repeat_hit = blk_valid && have_prev && (blk_data == prev);
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			prev <= '0;
			have_prev <= 1'b0;
			fail <= 1'b0;
		end else begin
			if (blk_valid) begin
				prev <= blk_data;
				have_prev <= 1'b1;
			end
			if (repeat_hit) fail <= 1'b1;
		end
	end
endmodule : cstm_crng

// ==== verilog/cstm_monitor.sv ====
// Top of the self-test monitor: power-up sequence, status and output gating.
module cstm_monitor #(
	parameter int NUM_KAT = cstm_pkg::NUM_KAT
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic host_approved_sel,
	input wire logic kat_done,
	input wire logic [NUM_KAT-1:0] kat_match,
	input wire logic [NUM_KAT-1:0] kat_is_pairwise,
	input wire logic [NUM_KAT-1:0] pairwise_ok,
	input wire logic [cstm_pkg::DRBG_STEPS-1:0] drbg_step_pass,
	input wire logic srom_done,
	input wire logic [cstm_pkg::DIGEST_W-1:0] srom_digest,
	input wire logic [cstm_pkg::DIGEST_W-1:0] srom_expected,
	input wire logic prom_valid,
	input wire logic [cstm_pkg::ROM_WORD_W-1:0] prom_word,
	input wire logic prom_last,
	input wire logic fwsig_done,
	input wire logic fwsig_ok,
	input wire logic trng_valid,
	input wire logic [cstm_pkg::TRNG_BLOCK_W-1:0] trng_block,
	input wire logic drbg_valid,
	input wire logic [cstm_pkg::DRBG_BLOCK_W-1:0] drbg_block,
	input wire logic keygen_done,
	input wire logic keygen_is_ec,
	input wire logic keygen_pair_ok,
	input wire logic fw_update_done,
	input wire logic fw_update_ok,
	output logic selftest_done,
	output logic secure_out_en,
	output logic public_out_en,
	output logic [1:0] status,
	output logic fw_update_accept,
	output logic keygen_accept,
	output logic in_error
);
	initial begin
		if (NUM_KAT < 1) $error("cstm_monitor: at least one known-answer test is needed.");
	end

	cstm_pkg::cstm_state_t state;
	cstm_pkg::cstm_state_t next_state;

	logic trng_fail;
	logic drbg_fail;
	logic prom_done;
	logic prom_pass;

	cstm_crng #(.W(cstm_pkg::TRNG_BLOCK_W)) u_trng_chk (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.blk_valid(trng_valid),
		.blk_data(trng_block),
		.fail(trng_fail)
	);

	cstm_crng #(.W(cstm_pkg::DRBG_BLOCK_W)) u_drbg_chk (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.blk_valid(drbg_valid),
		.blk_data(drbg_block),
		.fail(drbg_fail)
	);

	cstm_rom_check #(.W(cstm_pkg::ROM_WORD_W)) u_prom_chk (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.word_valid(prom_valid && (state == cstm_pkg::CSTM_PROM)),
		.word_data(prom_word),
		.word_last(prom_last),
		.done(prom_done),
		.pass(prom_pass)
	);

	// Per-test verdict: reference match, or key-pair consistency for pairwise tests.
	wire [NUM_KAT-1:0] kat_ok = (kat_match & ~kat_is_pairwise) |
		(pairwise_ok & kat_is_pairwise);
	wire kat_pass = (&kat_ok) && (&drbg_step_pass);
	wire srom_pass = (srom_digest == srom_expected);
	wire crng_fail = trng_fail || drbg_fail;
	wire operational = (state == cstm_pkg::CSTM_APPROVED) ||
		(state == cstm_pkg::CSTM_NON_APPROVED);
	wire keygen_fail = operational && keygen_done && !keygen_pair_ok;
	wire pass_state_sel = host_approved_sel;

	always_comb begin
		next_state = state;
		unique case (state)
			cstm_pkg::CSTM_KAT: begin
				if (kat_done) begin
					next_state = kat_pass ? cstm_pkg::CSTM_SROM : cstm_pkg::CSTM_ERROR;
				end
			end
			cstm_pkg::CSTM_SROM: begin
				if (srom_done) begin
					next_state = srom_pass ? cstm_pkg::CSTM_PROM : cstm_pkg::CSTM_ERROR;
				end
			end
			cstm_pkg::CSTM_PROM: begin
				if (prom_done) begin
					next_state = prom_pass ? cstm_pkg::CSTM_FWSIG : cstm_pkg::CSTM_ERROR;
				end
			end
			cstm_pkg::CSTM_FWSIG: begin
				if (fwsig_done) begin
					if (!fwsig_ok) begin
						next_state = cstm_pkg::CSTM_ERROR;
					end else if (pass_state_sel) begin
						next_state = cstm_pkg::CSTM_APPROVED;
					end else begin
						next_state = cstm_pkg::CSTM_NON_APPROVED;
					end
				end
			end
			cstm_pkg::CSTM_APPROVED, cstm_pkg::CSTM_NON_APPROVED: begin
				if (keygen_fail) next_state = cstm_pkg::CSTM_ERROR;
			end
			cstm_pkg::CSTM_ERROR: begin
				next_state = cstm_pkg::CSTM_ERROR;
			end
			default: begin
				next_state = cstm_pkg::CSTM_ERROR;
			end
		endcase
		if (crng_fail) next_state = cstm_pkg::CSTM_ERROR;
	end

	// Status seen on the output for each state.
	wire [1:0] next_status =
		(next_state == cstm_pkg::CSTM_ERROR) ? cstm_pkg::STATUS_ERROR :
		(next_state == cstm_pkg::CSTM_APPROVED) ? cstm_pkg::STATUS_APPROVED :
		(next_state == cstm_pkg::CSTM_NON_APPROVED) ? cstm_pkg::STATUS_NON_APPROVED :
		cstm_pkg::STATUS_BUSY;
	wire next_done = (next_state == cstm_pkg::CSTM_APPROVED) ||
		(next_state == cstm_pkg::CSTM_NON_APPROVED);
	wire next_accept = next_done && fw_update_done && fw_update_ok;
	wire next_kg_accept = next_done && keygen_done && keygen_pair_ok;

	// Sequence starts at reset by itself; there is no rerun input.
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state <= cstm_pkg::CSTM_KAT;
			status <= cstm_pkg::STATUS_BUSY;
			selftest_done <= 1'b0;
			secure_out_en <= 1'b0;
			public_out_en <= 1'b0;
			fw_update_accept <= 1'b0;
			keygen_accept <= 1'b0;
			in_error <= 1'b0;
		end else begin
			state <= next_state;
			status <= next_status;
			selftest_done <= next_done;
			secure_out_en <= next_done;
			public_out_en <= next_done;
			fw_update_accept <= next_accept;
			keygen_accept <= next_kg_accept;
			in_error <= (next_state == cstm_pkg::CSTM_ERROR);
		end
	end
endmodule : cstm_monitor

// ==== verilog/cstm_pkg.sv ====
// Package of constants and types for the crypto self-test monitor.
package cstm_pkg;
	localparam int TRNG_BLOCK_W = 16;
	localparam int DRBG_BLOCK_W = 128;
	localparam int DIGEST_W = 256;
	localparam int ROM_WORD_W = 16;
	localparam int NUM_KAT = 8;
	localparam logic [15:0] CSUM_GOOD = 16'hffff;
	localparam logic [1:0] STATUS_BUSY = 2'h0;
	localparam logic [1:0] STATUS_APPROVED = 2'h1;
	localparam logic [1:0] STATUS_NON_APPROVED = 2'h2;
	localparam logic [1:0] STATUS_ERROR = 2'h3;
	localparam int DRBG_STEP_INST = 0;
	localparam int DRBG_STEP_RESEED = 1;
	localparam int DRBG_STEP_ADDIN = 2;
	localparam int DRBG_STEP_GEN = 3;
	localparam int DRBG_STEPS = 4;
	typedef enum logic [2:0] {
		CSTM_KAT = 3'h0,
		CSTM_SROM = 3'h1,
		CSTM_PROM = 3'h2,
		CSTM_FWSIG = 3'h3,
		CSTM_APPROVED = 3'h4,
		CSTM_NON_APPROVED = 3'h5,
		CSTM_ERROR = 3'h6
	} cstm_state_t;

	// Ones-complement 16-bit add with end-around carry.
	function automatic logic [15:0] csum_add(input logic [15:0] a, input logic [15:0] b);
		logic [16:0] s;
		s = {1'b0, a} + {1'b0, b};
		csum_add = s[15:0] + {15'h0, s[16]};
	endfunction : csum_add
endpackage : cstm_pkg

// ==== verilog/cstm_rom_check.sv ====
// Streaming ROM checker: ones-complement checksum over a word stream.
module cstm_rom_check #(
	parameter int W = 16
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic word_valid,
	input wire logic [W-1:0] word_data,
	input wire logic word_last,
	output logic done,
	output logic pass
);
	initial begin
		if (W != 16) $error("cstm_rom_check: checksum is defined on 16-bit words.");
	end
	logic [15:0] acc;
	wire [15:0] next_acc = cstm_pkg::csum_add(acc, word_data);
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			acc <= 16'h0;
			done <= 1'b0;
			pass <= 1'b0;
		end else if (word_valid && !done) begin
			acc <= next_acc;
			if (word_last) begin
				done <= 1'b1;
				pass <= (next_acc == cstm_pkg::CSUM_GOOD);
			end
		end
	end
endmodule : cstm_rom_check
